/* evr_router.sv */
`timescale 1ns/100ps
//
// Contract
// - four independent channels, each own source mux
// - one source may feed several channels
// - events last one cycle, pin levels continuous
// - event reaches users within two cycles
// - filter passes only after equal consecutive samples
// - single quadrature decoder attached to channel zero
// - decoder events strobe/data: none, index, down, up
// - quadrature state is phase a concatenated phase b
// - b leading counts up, a leading down
// - error on index off count_minimum, or count_minimum pass
// - select zero or absent source routes nothing
// - software events override the selected source
// - source code decodes per group and low nibble
// - source select eight bits, read/write, reset zero
// - software strobe injects one-cycle event per channel
// - one shared prescaler, each channel taps a power-of-two division
// - filter code 0..7 means 1..8 samples
module evr_router
    import evr_pkg::*;
#(
    parameter int         NCH        = EVR_NCH,
    parameter logic [7:0] TC_PRESENT = 8'h57
)(
    input  wire logic           clk_sys,
    input  wire logic           rst_b,
    input  wire logic           ce,
    input  wire logic [7:0]     paddr,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    input  wire logic           rtc_ovf,
    input  wire logic           rtc_cmp,
    input  wire logic           ac_ch0,
    input  wire logic           ac_ch1,
    input  wire logic           ac_win,
    input  wire logic           adc_ch0,
    input  wire logic [47:0]    port_pin_lvl,
    input  wire logic [63:0]    tc_evt,
    output logic [NCH-1:0]      ev_strobe,
    output logic [NCH-1:0]      ev_data,
    output logic [15:0]         qd_count,
    output logic                qd_error
);
    if (NCH < 2 || NCH > 4)
    begin : g_chk
        $error("NCH must be 2 to 4");
    end

    logic [7:0]           mux_q [NCH];
    logic [7:0]           mux_d [NCH];
    logic [6:0]           ctrl_q [NCH];
    logic [6:0]           ctrl_d [NCH];
    logic [7:0]           stb_q;
    logic [7:0]           stb_d;
    logic [7:0]           dat_q;
    logic [7:0]           dat_d;
    logic [15:0]          qper_q;
    logic [15:0]          qper_d;
    logic [31:0]          prdata_q;
    logic [31:0]          prdata_d;
    logic                 pslverr_q;
    logic                 pslverr_d;
    logic [EVR_PRE_W-1:0] pre_q;
    logic [EVR_PRE_W-1:0] pre_d;
    logic [NCH-1:0]       evs_q;
    logic [NCH-1:0]       evs_d;
    logic [NCH-1:0]       evd_q;
    logic [NCH-1:0]       evd_d;
    logic [NCH-1:0]       sw_on;
    logic [NCH:0]         raw;
    logic [NCH:0]         filt;
    logic [1:0]           qd_evt;
    logic                 setup;
    logic                 wr;
    logic                 sw_hit;
    logic                 err_clr;
    logic                 addr_ok;
    logic [31:0]          rd_val;
    logic [5:0]           pa_idx;

    // unlisted codes and absent timers fall through to zero
    function automatic logic src_sel(input logic [7:0] code);
        logic [3:0]           grp;
        logic [3:0]           lo;
        logic [2:0]           tidx;
        logic [EVR_PRE_W-1:0] mask;
        grp     = code[7:4];
        lo      = code[3:0];
        tidx    = {grp[1:0], lo[3]};
        mask    = (15'h0001 << lo) - 15'h0001;
        src_sel = 1'b0;
        case (grp)
            G_NONE: src_sel = ((lo == RTC_OVF_LO) & rtc_ovf) | ((lo == RTC_CMP_LO) & rtc_cmp);
            G_AC: src_sel = ((lo == AC_CH0_LO) & ac_ch0) | ((lo == AC_CH1_LO) & ac_ch1)
                          | ((lo == AC_WIN_LO) & ac_win);
            G_ADC: src_sel = (lo == ADC_CH0_LO) & adc_ch0;
            // pins are low-level sensed, so a held low repeats every cycle
            4'h5, 4'h6, 4'h7: src_sel = ~port_pin_lvl[{grp[1:0] - 2'h1, lo}];
            G_PRE: src_sel = ((pre_q & mask) == '0);
            4'hC, 4'hD, 4'hE, 4'hF: src_sel = TC_PRESENT[tidx] & (lo[2:1] != 2'h1) & tc_evt[{tidx, lo[2:0]}];
            default: src_sel = 1'b0;
        endcase
    endfunction

    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & ce;
    assign sw_hit  = wr & (paddr == A_STROBE);
    assign err_clr = wr & (paddr == A_QSTAT) & pwdata[QSTAT_ERR];
    assign pa_idx  = {mux_q[0][5:4] - 2'h1, mux_q[0][3:0]};

    // phase b is the pin above the phase a pin on channel zero; other codes would index past the pins
    assign raw[NCH] = (mux_q[0][7:4] inside {4'h5, 4'h6, 4'h7}) & (mux_q[0][2:0] != 3'h7)
                      & ~port_pin_lvl[pa_idx + 6'h01];

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic qd_sel;
        logic src_hit;
        // a process, not an assign, so that sources read inside the function wake it
        always_comb
        begin
            src_hit = src_sel(mux_q[i]);
        end
        assign raw[i]   = src_hit;
        assign qd_sel   = (i == 0) && ctrl_q[0][CTRL_QDEN];
        assign sw_on[i] = sw_hit & (pwdata[i] | dat_q[i]);
        assign evs_d[i] = sw_on[i] ? pwdata[i] : (qd_sel ? qd_evt[1] : filt[i]);
        assign evd_d[i] = sw_on[i] ? dat_q[i] : (qd_sel & qd_evt[0]);
    end

    for (genvar i = 0; i <= NCH; i++)
    begin : g_filt
        evr_filter u_filt (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .ce      (ce),
            .len     (ctrl_q[(i == NCH) ? 0 : i][CTRL_FILT_LSB +: 3]),
            .evt_in  (raw[i]),
            .evt_out (filt[i])
        );
    end

    // filtered low-events are inverted back into phase levels
    evr_quadrature_decoder u_quadrature_decoder (
        .clk_sys       (clk_sys),
        .rst_b         (rst_b),
        .ce            (ce),
        .enable        (ctrl_q[0][CTRL_QDEN]),
        .phase_a_input (~filt[0]),
        .phase_b_input (~filt[NCH]),
        .index_input   (filt[1]),
        .index_enable  (ctrl_q[1][CTRL_QDIEN]),
        .irm           (ctrl_q[1][CTRL_IRM_LSB +: 2]),
        .period        (qper_q),
        .err_clr       (err_clr),
        .qd_evt        (qd_evt),
        .count         (qd_count),
        .error         (qd_error)
    );

    always_comb
    begin
        mux_d  = mux_q;
        ctrl_d = ctrl_q;
        stb_d  = stb_q;
        dat_d  = dat_q;
        qper_d = qper_q;
        pre_d  = pre_q + EVR_PRE_W'(1);
        rd_val = 32'h0000_0000;
        addr_ok = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            if (paddr == A_MUX0 + 8'(4 * i))
            begin
                addr_ok = 1'b1;
                rd_val  = {24'h00_0000, mux_q[i]};
                if (wr)
                    mux_d[i] = pwdata[7:0];
            end
            if (paddr == A_CTRL0 + 8'(4 * i))
            begin
                addr_ok = 1'b1;
                rd_val  = {25'h000_0000, ctrl_q[i]};
                if (wr)
                    ctrl_d[i] = pwdata[6:0];
            end
        end
        case (paddr)
            A_STROBE:
            begin
                addr_ok = 1'b1;
                rd_val  = {24'h00_0000, stb_q};
                if (wr)
                    stb_d = pwdata[7:0];
            end
            A_DATA:
            begin
                addr_ok = 1'b1;
                rd_val  = {24'h00_0000, dat_q};
                if (wr)
                    dat_d = pwdata[7:0];
            end
            A_QPER:
            begin
                addr_ok = 1'b1;
                rd_val  = {16'h0000, qper_q};
                if (wr)
                    qper_d = pwdata[15:0];
            end
            A_QSTAT:
            begin
                addr_ok = 1'b1;
                rd_val  = {15'h0000, qd_error, qd_count};
            end
            default: addr_ok = addr_ok;
        endcase
        // read data and error are captured in setup, held through access
        prdata_d  = setup ? rd_val : prdata_q;
        pslverr_d = setup ? ~addr_ok : (psel & pslverr_q);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                mux_q[i]  <= MUX_RST;
                ctrl_q[i] <= CTRL_RST;
            end
            stb_q     <= SW_RST;
            dat_q     <= SW_RST;
            qper_q    <= QPER_RST;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pre_q     <= '0;
            evs_q     <= '0;
            evd_q     <= '0;
        end
        else if (ce)
        begin
            mux_q     <= mux_d;
            ctrl_q    <= ctrl_d;
            stb_q     <= stb_d;
            dat_q     <= dat_d;
            qper_q    <= qper_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            pre_q     <= pre_d;
            evs_q     <= evs_d;
            evd_q     <= evd_d;
        end
    end

    // a frozen block must not complete a bus transfer
    assign pready    = ce;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign ev_strobe = evs_q;
    assign ev_data   = evd_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_sw0;
        sw_hit && pwdata[0] && mux_q[0] == MUX_RST && !ctrl_q[0][CTRL_QDEN];
    endsequence
    sequence s_quiet;
        ce && !sw_hit && mux_q[0] == MUX_RST && !ctrl_q[0][CTRL_QDEN];
    endsequence

    property p_sw_once;
        s_sw0 ##1 s_quiet |=> evs_q[0] == 1'b0;
    endproperty
    a_sw_once: assert property (p_sw_once) else $error("software event lasted over one cycle");

    property p_sw_in;
        sw_hit && sw_on[0] |=> evs_q[0] == $past(pwdata[0]) && evd_q[0] == $past(dat_q[0]);
    endproperty
    a_sw_in: assert property (p_sw_in) else $error("software event not injected");

    property p_zero;
        s_quiet |=> !evs_q[0];
    endproperty
    a_zero: assert property (p_zero) else $error("event routed with select zero");

    property p_rst;
        $rose(rst_b) |-> mux_q[0] == MUX_RST && mux_q[1] == MUX_RST && evs_q == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("select not zero after reset");

    property p_lat;
        ce && !sw_hit && mux_q[1] == {G_NONE, RTC_OVF_LO} && ctrl_q[1][2:0] == 3'h0 && rtc_ovf |=> evs_q[1];
    endproperty
    a_lat: assert property (p_lat) else $error("event late on channel one");

    property p_same;
        ce && !sw_hit && mux_q[0] == mux_q[1] && !ctrl_q[0][CTRL_QDEN]
            && ctrl_q[0][2:0] == 3'h0 && ctrl_q[1][2:0] == 3'h0 |=> evs_q[0] == evs_q[1];
    endproperty
    a_same: assert property (p_same) else $error("shared source differs between channels");

    property p_pre1;
        ce && !sw_hit && mux_q[1] == {G_PRE, 4'h0} && ctrl_q[1][2:0] == 3'h0 |=> evs_q[1];
    endproperty
    a_pre1: assert property (p_pre1) else $error("undivided prescaler missed a cycle");

    property p_resv;
        ce && !sw_hit && mux_q[NCH-1][7:4] == G_NONE && mux_q[NCH-1][3:1] != 3'h4 |=> !evs_q[NCH-1];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved code routed an event");
endmodule

/* evr_pkg.sv */
package evr_pkg;
    localparam int          EVR_NCH      = 4;
    localparam int          EVR_PRE_W    = 15;
    localparam int          EVR_CNT_W    = 16;
    localparam logic [7:0]  A_MUX0       = 8'h00;
    localparam logic [7:0]  A_CTRL0      = 8'h10;
    localparam logic [7:0]  A_STROBE     = 8'h20;
    localparam logic [7:0]  A_DATA       = 8'h24;
    localparam logic [7:0]  A_QPER       = 8'h28;
    localparam logic [7:0]  A_QSTAT      = 8'h2C;
    localparam logic [7:0]  MUX_RST      = 8'h00;
    localparam logic [6:0]  CTRL_RST     = 7'h00;
    localparam logic [7:0]  SW_RST       = 8'h00;
    localparam logic [15:0] QPER_RST     = 16'hFFFF;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam int          CTRL_FILT_LSB = 0;
    localparam int          CTRL_QDEN    = 3;
    localparam int          CTRL_QDIEN   = 4;
    localparam int          CTRL_IRM_LSB = 5;
    localparam int          QSTAT_ERR    = 16;
    localparam logic [3:0]  G_NONE       = 4'h0;
    localparam logic [3:0]  G_AC         = 4'h1;
    localparam logic [3:0]  G_ADC        = 4'h2;
    localparam logic [3:0]  G_PRE        = 4'h8;
    localparam logic [3:0]  RTC_OVF_LO   = 4'h8;
    localparam logic [3:0]  RTC_CMP_LO   = 4'h9;
    localparam logic [3:0]  AC_CH0_LO    = 4'h0;
    localparam logic [3:0]  AC_CH1_LO    = 4'h1;
    localparam logic [3:0]  AC_WIN_LO    = 4'h2;
    localparam logic [3:0]  ADC_CH0_LO   = 4'h0;
    localparam logic [1:0]  QD_NONE      = 2'h0;
    localparam logic [1:0]  QD_INDEX     = 2'h1;
    localparam logic [1:0]  QD_DOWN      = 2'h2;
    localparam logic [1:0]  QD_UP        = 2'h3;
    localparam logic [2:0]  FILT_RUN_MAX = 3'h7;
endpackage

/* evr_filter.sv */
`timescale 1ns/100ps
module evr_filter
    import evr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic [2:0] len,
    input  wire logic       evt_in,
    output logic            evt_out
);
    logic       prev_q;
    logic [2:0] run_q;
    logic [2:0] run_d;

    // run counts earlier samples equal to the present one, saturating
    always_comb
    begin
        if (evt_in != prev_q)
            run_d = 3'h0;
        else if (run_q == FILT_RUN_MAX)
            run_d = FILT_RUN_MAX;
        else
            run_d = run_q + 3'h1;
        evt_out = evt_in & (run_d >= len);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_q <= 1'b0;
            run_q  <= 3'h0;
        end
        else if (ce)
        begin
            prev_q <= evt_in;
            run_q  <= run_d;
        end
    end
endmodule

/* evr_quadrature_decoder.sv */
`timescale 1ns/100ps
module evr_quadrature_decoder
    import evr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        enable,
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        index_input,
    input  wire logic        index_enable,
    input  wire logic [1:0]  irm,
    input  wire logic [15:0] period,
    input  wire logic        err_clr,
    output logic [1:0]       qd_evt,
    output logic [15:0]      count,
    output logic             error
);
    logic [1:0]  state_q;
    logic [1:0]  state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        err_q;
    logic        err_d;
    logic        idx_hit;
    logic        wrap;

    always_comb
    begin
        state_d = {phase_a_input, phase_b_input};
        idx_hit = enable & index_enable & index_input & (state_d == irm);
        qd_evt  = QD_NONE;
        // one count per valid gray step, a double step is dropped
        case ({state_q, state_d})
            4'h1, 4'h7, 4'hE, 4'h8: qd_evt = QD_UP;
            4'h2, 4'hB, 4'hD, 4'h4: qd_evt = QD_DOWN;
            default: qd_evt = QD_NONE;
        endcase
        if (!enable)
            qd_evt = QD_NONE;
        // index resets the count, so it outranks a step in the same cycle
        if (idx_hit)
            qd_evt = QD_INDEX;
        cnt_d = cnt_q;
        wrap  = 1'b0;
        case (qd_evt)
            QD_UP:
            begin
                wrap  = (cnt_q == period);
                cnt_d = wrap ? CNT_RST : cnt_q + 16'h0001;
            end
            QD_DOWN:
            begin
                wrap  = (cnt_q == CNT_RST);
                cnt_d = wrap ? period : cnt_q - 16'h0001;
            end
            QD_INDEX: cnt_d = CNT_RST;
            default: cnt_d = cnt_q;
        endcase
        // set wins over a clear in the same cycle
        err_d = (idx_hit & (cnt_q != CNT_RST)) | (wrap & index_enable) | (err_q & ~err_clr);
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= 2'h0;
            cnt_q   <= CNT_RST;
            err_q   <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            err_q   <= err_d;
        end
    end

    assign count = cnt_q;
    assign error = err_q;

    property p_qd_up;
        @(posedge clk_sys) disable iff (!rst_b)
        enable && !idx_hit && state_q == 2'h0 && state_d == 2'h1 |-> qd_evt == QD_UP;
    endproperty
    a_qd_up: assert property (p_qd_up) else $error("forward step not counted up");

    property p_qd_down;
        @(posedge clk_sys) disable iff (!rst_b)
        enable && !idx_hit && state_q == 2'h0 && state_d == 2'h2 |-> qd_evt == QD_DOWN;
    endproperty
    a_qd_down: assert property (p_qd_down) else $error("reverse step not counted down");

    property p_qd_err;
        @(posedge clk_sys) disable iff (!rst_b)
        ce && idx_hit && cnt_q != CNT_RST |=> error && count == CNT_RST;
    endproperty
    a_qd_err: assert property (p_qd_err) else $error("index off count_minimum did not flag error");

    property p_qd_idx;
        @(posedge clk_sys) disable iff (!rst_b)
        ce && enable && index_enable && index_input && state_d == irm |-> qd_evt == QD_INDEX ##1 count == CNT_RST;
    endproperty
    a_qd_idx: assert property (p_qd_idx) else $error("index event not emitted");
endmodule

/* evr_gen_model.sv */
`timescale 1ns/100ps
module evr_gen_model
    import evr_pkg::*;
(
    input  wire logic        clk_sys,
    output logic [5:0]       src,
    output logic [47:0]      pins
);
    initial
    begin
        src  = 6'h00;
        pins = 48'hFFFF_FFFF_FFFF;
    end

    // source k held high for n cycles, then released
    task automatic pulse(input int k, input int n);
        @(posedge clk_sys);
        src[k] <= 1'b1;
        repeat (n) @(posedge clk_sys);
        src[k] <= 1'b0;
    endtask

    // two adjacent pins of port 0 act as phase inputs, a on pin 0 and b on pin 1
    task automatic phase(input logic [1:0] ab, input int hold);
        @(posedge clk_sys);
        pins[0] <= ab[1];
        pins[1] <= ab[0];
        repeat (hold) @(posedge clk_sys);
    endtask

    // index mark on pin 2 of port 0, low while the mark passes
    task automatic index(input logic lvl, input int hold);
        @(posedge clk_sys);
        pins[2] <= lvl;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule

/* tb_event_channel_router_quadrature_decoder.sv */
`timescale 1ns/100ps
module tb_event_channel_router_quadrature_decoder;
    import evr_pkg::*;

    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [5:0]  src;
    logic [47:0] pins;
    logic [63:0] tc_evt;
    logic [3:0]  ev_strobe;
    logic [3:0]  ev_data;
    logic [15:0] qd_count;
    logic        qd_error;
    int          n_errors;
    int          samples_checked;
    int          hits [4];
    int          dhits [4];

    evr_gen_model gen (.clk_sys(clk_sys), .src(src), .pins(pins));

    evr_router #(.NCH(4)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rtc_ovf(src[0]), .rtc_cmp(src[1]), .ac_ch0(src[2]), .ac_ch1(src[3]), .ac_win(src[4]),
        .adc_ch0(src[5]), .port_pin_lvl(pins), .tc_evt(tc_evt),
        .ev_strobe(ev_strobe), .ev_data(ev_data), .qd_count(qd_count), .qd_error(qd_error));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        for (int c = 0; c < 4; c++)
        begin
            hits[c] += (ev_strobe[c] === 1'b1);
            dhits[c] += (ev_strobe[c] === 1'b1 && ev_data[c] === 1'b1);
        end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check(d, exp);
    endtask

    task automatic clear_hits();
        for (int c = 0; c < 4; c++)
        begin
            hits[c] = 0;
            dhits[c] = 0;
        end
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 4; i++)
            rd(A_MUX0 + 8'(4 * i), 32'h0000_0000);
        rd(A_CTRL0, 32'h0000_0000);
        rd(A_QPER, 32'h0000_FFFF);
        rd(A_QSTAT, 32'h0000_0000);
        wr(A_MUX0 + 8'h08, 32'hFFFF_FFFF);
        rd(A_MUX0 + 8'h08, 32'h0000_00FF);
        wr(A_MUX0 + 8'h08, 32'h0000_0000);
        // unmapped word must refuse, not alias a register
        apb(1'b1, 8'h30, 32'hFFFF_FFFF, d, e);
        apb(1'b0, 8'h30, 32'h0000_0000, d, e);
        check(32'(e), 32'h0000_0001);
        check(d, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_route();
        logic [7:0] code [6] = '{8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h20};
        for (int k = 0; k < 6; k++)
        begin
            wr(A_MUX0 + 8'h0C, 32'(code[k]));
            wr(A_MUX0 + 8'h04, 32'(code[k]));
            gen.pulse(k, 1);
            #1;
            check(32'(ev_strobe), 32'h0000_000A);
            @(posedge clk_sys);
            #1;
            check(32'(ev_strobe), 32'h0000_0000);
            @(posedge clk_sys);
        end
        // reserved code and zero both give silence
        wr(A_MUX0 + 8'h0C, 32'h0000_000A);
        wr(A_MUX0 + 8'h04, 32'h0000_0000);
        clear_hits();
        for (int k = 0; k < 6; k++)
            gen.pulse(k, 1);
        repeat (3) @(posedge clk_sys);
        check(32'(hits[3] + hits[1]), 32'h0000_0000);
        // slot 3 has no timer behind it, so it must stay silent
        wr(A_MUX0 + 8'h04, 32'h0000_00C0);
        wr(A_MUX0 + 8'h0C, 32'h0000_00D8);
        clear_hits();
        tc_evt <= 64'hFFFF_FFFF_FFFF_FFFF;
        @(posedge clk_sys);
        tc_evt <= 64'h0000_0000_0000_0000;
        repeat (3) @(posedge clk_sys);
        check(32'(hits[1]), 32'h0000_0001);
        check(32'(hits[3]), 32'h0000_0000);
        wr(A_MUX0 + 8'h04, 32'h0000_0080);
        wr(A_MUX0 + 8'h0C, 32'h0000_0081);
        // off the edge, so the counting process and the clear never share a time step
        #1;
        clear_hits();
        repeat (8) @(posedge clk_sys);
        #1;
        check(32'(hits[1]), 32'h0000_0008);
        check(32'(hits[3]), 32'h0000_0004);
        @(posedge clk_sys);
        wr(A_MUX0 + 8'h04, 32'h0000_0000);
        $display("test route done");
    endtask

    task automatic t_filter();
        int len [4] = '{2, 2, 7, 7};
        int n [4]   = '{2, 3, 7, 8};
        wr(A_MUX0 + 8'h0C, 32'h0000_0008);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_CTRL0 + 8'h0C, 32'(len[i]));
            clear_hits();
            gen.pulse(0, n[i]);
            repeat (4) @(posedge clk_sys);
            check(32'(hits[3]), 32'(n[i] > len[i] ? n[i] - len[i] : 0));
        end
        wr(A_CTRL0 + 8'h0C, 32'h0000_0000);
        wr(A_MUX0 + 8'h0C, 32'h0000_0000);
        $display("test filter done");
    endtask

    task automatic t_soft();
        clear_hits();
        wr(A_DATA, 32'h0000_0005);
        wr(A_STROBE, 32'h0000_0003);
        repeat (3) @(posedge clk_sys);
        check(32'(hits[0]), 32'h0000_0001);
        check(32'(hits[1]), 32'h0000_0001);
        check(32'(hits[2]), 32'h0000_0000);
        check(32'(dhits[0]), 32'h0000_0001);
        check(32'(dhits[1]), 32'h0000_0000);
        $display("test soft done");
    endtask

    task automatic t_quadrature_decoder();
        logic [1:0] up [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
        logic [1:0] dn [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
        wr(A_MUX0, 32'h0000_0050);
        wr(A_CTRL0, 32'h0000_0008);
        wr(A_CTRL0 + 8'h04, 32'h0000_0010);
        wr(A_QPER, 32'h0000_000F);
        rd(A_QSTAT, 32'h0000_0000);
        clear_hits();
        for (int i = 0; i < 4; i++)
            gen.phase(up[i], 4);
        check(32'(dhits[0]), 32'h0000_0004);
        check(32'(hits[0]), 32'h0000_0004);
        rd(A_QSTAT, 32'h0000_0004);
        clear_hits();
        for (int i = 0; i < 4; i++)
            gen.phase(dn[i], 4);
        check(32'(hits[0] - dhits[0]), 32'h0000_0004);
        rd(A_QSTAT, 32'h0000_0000);
        gen.phase(2'b01, 4);
        rd(A_QSTAT, 32'h0001_000F);
        wr(A_QSTAT, 32'h0001_0000);
        rd(A_QSTAT, 32'h0000_000F);
        // index recognised in state 01 while the count is off count_minimum
        wr(A_MUX0 + 8'h04, 32'h0000_0052);
        wr(A_CTRL0 + 8'h04, 32'h0000_0030);
        gen.index(1'b0, 3);
        gen.index(1'b1, 3);
        rd(A_QSTAT, 32'h0001_0000);
        wr(A_QSTAT, 32'h0001_0000);
        gen.index(1'b0, 3);
        gen.index(1'b1, 3);
        rd(A_QSTAT, 32'h0000_0000);
        $display("test quadrature_decoder done");
    endtask

    initial
    begin
        n_errors = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tc_evt = 64'h0000_0000_0000_0000;
        clear_hits();
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_route();
        t_filter();
        t_soft();
        t_quadrature_decoder();
        tally_and_finish();
    end

    initial
    begin
        #(20 * 20000);
        n_errors++;
        tally_and_finish();
    end
endmodule
